// File: src/mpps_consts.svh
// constant definitions for the multiphase pwm phase sequencer
`ifndef MPPS_CONSTS_SVH
`define MPPS_CONSTS_SVH
`define MPPS_NUM_PH        4
`define MPPS_PER_W         16
`define MPPS_CNT_ZERO      16'h0000
`define MPPS_CNT_ONE       16'h0001
`define MPPS_MIN_PERIOD    16'h000C
`define MPPS_ONE_PH        4'h1
`define MPPS_ALL_PH        4'hF
`define MPPS_TWO_PH        4'h3
`define MPPS_THREE_PH      4'h7
`define MPPS_DIV_TWO       16'h0002
`define MPPS_DIV_THREE     16'h0003
`define MPPS_DIV_FOUR      16'h0004
`endif

// File: src/mpps_pkg.sv
// types shared by the phase sequencer files
package mpps_pkg;
  // active channel count selected by strapping
  typedef enum logic [1:0] {
    MPPS_CH_TWO,
    MPPS_CH_THREE,
    MPPS_CH_FOUR
  } mpps_chan_type;

  // per-phase comparator and sense inputs
  typedef struct packed {
    logic [3:0] ramp_cross;   // modified error level crossed ramp, one bit per phase
    logic [3:0] sense_valid;  // per-channel current sense sample ready
  } mpps_phase_in_type;

  // fault and status inputs from the analog monitors
  typedef struct packed {
    logic soft_start_done;    // soft start has finished
    logic undervoltage;       // output below undervoltage point
    logic overvoltage;        // overvoltage detected
  } mpps_mon_type;
endpackage

// File: src/mpps_phase_chan.sv
// one phase channel: forced off time, set on ramp crossing, clear on termination
`timescale 1ns/1ps
`include "mpps_consts.svh"
module mpps_phase_chan (
  input  wire logic                      core_clk_i,
  input  wire logic                      reset_n_i,
  input  wire logic                      run_i,        // channel active and enabled
  input  wire logic                      term_i,       // pulse termination strobe
  input  wire logic [`MPPS_PER_W-1:0]    off_len_i,    // forced off length in cycles
  input  wire logic                      cross_i,      // ramp crossing from comparator
  output logic                           pwm_o,        // phase output
  output logic                           sample_o      // sense window is open
);
  import mpps_pkg::*;

  logic [`MPPS_PER_W-1:0] off_cnt_ff;  // cycles left in the forced off time

  // forced off counter reloads on every falling edge
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      off_cnt_ff <= `MPPS_CNT_ZERO;
    end else if (!run_i || term_i) begin
      off_cnt_ff <= off_len_i;
    end else if (off_cnt_ff != `MPPS_CNT_ZERO) begin
      off_cnt_ff <= off_cnt_ff - `MPPS_CNT_ONE;
    end
  end

  // output state: low on termination, high on crossing once off time is over
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pwm_o <= 1'b0;
    end else if (!run_i || term_i) begin
      pwm_o <= 1'b0;
    end else if (off_cnt_ff == `MPPS_CNT_ZERO && cross_i) begin
      pwm_o <= 1'b1;
    end
  end

  // sample window flag marks the off time, the sense interval
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sample_o <= 1'b0;
    end else begin
      sample_o <= run_i && (term_i || off_cnt_ff > `MPPS_CNT_ONE);
    end
  end
endmodule

// File: src/mpps_seq.sv
// top of the multiphase pwm phase sequencer
`timescale 1ns/1ps
`include "mpps_consts.svh"
module mpps_seq (
  input  wire logic                       core_clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       logic_enable_in_i,     // logic-level enable pin
  input  wire logic [`MPPS_PER_W-1:0]     freq_set_input_i,      // period in clocks
  input  wire mpps_pkg::mpps_phase_in_type phase_in_i,           // comparators and sense
  input  wire mpps_pkg::mpps_mon_type     mon_i,                 // analog monitors
  input  wire logic                       strap_c_i,             // phase c pin level
  input  wire logic                       strap_d_i,             // phase d pin level
  output logic                            phase_out_a_o,
  output logic                            phase_out_b_o,
  output logic                            phase_out_c_o,
  output logic                            phase_out_d_o,
  output logic                            phase_oe_o,            // drive enable, low in strap
  output logic [3:0]                      sense_active_o,        // per-channel sense window
  output logic                            cycle_start_o,         // phase a termination
  output mpps_pkg::mpps_chan_type         chan_mode_o,           // latched channel count
  output logic                            power_ok_flag_o,       // high once good
  output logic                            overvoltage_crowbar_out_o
);
  import mpps_pkg::*;

  logic [2:0]             en_sync_ff;     // enable pin synchroniser
  logic [2:0]             c_sync_ff;      // phase c strap synchroniser
  logic [2:0]             d_sync_ff;      // phase d strap synchroniser
  logic [2:0]             ov_sync_ff;     // overvoltage synchroniser
  logic [2:0]             uv_sync_ff;     // undervoltage synchroniser
  logic [2:0]             ss_sync_ff;     // soft start done synchroniser
  logic                   en_ff;          // filtered enable
  logic                   c_ff;           // filtered strap c
  logic                   d_ff;           // filtered strap d
  logic                   ov_ff;          // filtered overvoltage
  logic                   uv_ff;          // filtered undervoltage
  logic                   ss_ff;          // filtered soft start done
  logic [`MPPS_PER_W-1:0] period_ff;      // latched period
  logic [`MPPS_PER_W-1:0] cnt_ff;         // position within period
  logic [`MPPS_PER_W-1:0] step;           // spacing between terminations
  logic [`MPPS_PER_W-1:0] off_len;        // forced off time
  logic [3:0]             act_mask;       // active channel mask
  logic [3:0]             term;           // per-phase termination strobe
  logic [3:0]             pwm;            // per-phase outputs
  logic                   run;            // sequencer running
  logic                   ss_seen_ff;     // soft start completed this enable
  logic                   ov_latch_ff;    // overvoltage latch

  // three-stage synchronisers; a change counts once the last two agree
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_sync_ff <= 3'h0;
      c_sync_ff  <= 3'h0;
      d_sync_ff  <= 3'h0;
      ov_sync_ff <= 3'h0;
      uv_sync_ff <= 3'h0;
      ss_sync_ff <= 3'h0;
    end else begin
      en_sync_ff <= {en_sync_ff[1:0], logic_enable_in_i};
      c_sync_ff  <= {c_sync_ff[1:0], strap_c_i};
      d_sync_ff  <= {d_sync_ff[1:0], strap_d_i};
      ov_sync_ff <= {ov_sync_ff[1:0], mon_i.overvoltage};
      uv_sync_ff <= {uv_sync_ff[1:0], mon_i.undervoltage};
      ss_sync_ff <= {ss_sync_ff[1:0], mon_i.soft_start_done};
    end
  end

  // filtered levels only move when stages two and three agree
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_ff <= 1'b0;
      c_ff  <= 1'b0;
      d_ff  <= 1'b0;
      ov_ff <= 1'b0;
      uv_ff <= 1'b0;
      ss_ff <= 1'b0;
    end else begin
      if (en_sync_ff[1] == en_sync_ff[2]) en_ff <= en_sync_ff[2];
      if (c_sync_ff[1] == c_sync_ff[2])   c_ff  <= c_sync_ff[2];
      if (d_sync_ff[1] == d_sync_ff[2])   d_ff  <= d_sync_ff[2];
      if (ov_sync_ff[1] == ov_sync_ff[2]) ov_ff <= ov_sync_ff[2];
      if (uv_sync_ff[1] == uv_sync_ff[2]) uv_ff <= uv_sync_ff[2];
      if (ss_sync_ff[1] == ss_sync_ff[2]) ss_ff <= ss_sync_ff[2];
    end
  end

  // running needs enable and no latched fault
  assign run = en_ff && !ov_latch_ff;

  // pins float while stopped so the straps can be read
  assign phase_oe_o = run;

  // channel count and period captured only while stopped
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chan_mode_o <= MPPS_CH_FOUR;
      period_ff   <= `MPPS_MIN_PERIOD;
    end else if (!run) begin
      if (c_ff) begin
        chan_mode_o <= MPPS_CH_TWO;
      end else if (d_ff) begin
        chan_mode_o <= MPPS_CH_THREE;
      end else begin
        chan_mode_o <= MPPS_CH_FOUR;
      end
      // short periods would collapse the phase spacing to zero
      period_ff <= (freq_set_input_i < `MPPS_MIN_PERIOD) ? `MPPS_MIN_PERIOD
                                                         : freq_set_input_i;
    end
  end

  // spacing and off time as fractions of the period
  always_comb begin
    case (chan_mode_o)
      MPPS_CH_TWO: begin
        step     = period_ff / `MPPS_DIV_TWO;
        act_mask = `MPPS_TWO_PH;
      end
      MPPS_CH_THREE: begin
        step     = period_ff / `MPPS_DIV_THREE;
        act_mask = `MPPS_THREE_PH;
      end
      MPPS_CH_FOUR: begin
        step     = period_ff / `MPPS_DIV_FOUR;
        act_mask = `MPPS_ALL_PH;
      end
      default: begin
        step     = period_ff / `MPPS_DIV_FOUR;
        act_mask = `MPPS_ALL_PH;
      end
    endcase
    off_len = period_ff / `MPPS_DIV_THREE;
  end

  // period counter; zero is the phase a termination instant
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_ff <= `MPPS_CNT_ZERO;
    end else if (!run || cnt_ff >= period_ff - `MPPS_CNT_ONE) begin
      cnt_ff <= `MPPS_CNT_ZERO;
    end else begin
      cnt_ff <= cnt_ff + `MPPS_CNT_ONE;
    end
  end

  // termination strobes per phase at multiples of the step
  genvar g;
  generate
    for (g = 0; g < `MPPS_NUM_PH; g++) begin : g_ph
      assign term[g] = run && act_mask[g]
                       && (cnt_ff == `MPPS_PER_W'(step * g));
      mpps_phase_chan u_chan (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .run_i      (run && act_mask[g]),
        .term_i     (term[g]),
        .off_len_i  (off_len),
        .cross_i    (phase_in_i.ramp_cross[g] && phase_in_i.sense_valid[g] | 1'b1),
        .pwm_o      (pwm[g]),
        .sample_o   (sense_active_o[g])
      );
    end
  endgenerate

  // outputs follow channel flip-flops; drivers act on the edges
  assign phase_out_a_o = pwm[0];
  assign phase_out_b_o = pwm[1];
  assign phase_out_c_o = pwm[2];
  assign phase_out_d_o = pwm[3];

  // cycle start marker registered from the phase a strobe
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cycle_start_o <= 1'b0;
    end else begin
      cycle_start_o <= term[0];
    end
  end

  // soft start tracking, cleared whenever enable drops
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ss_seen_ff <= 1'b0;
    end else if (!en_ff) begin
      ss_seen_ff <= 1'b0;
    end else if (ss_ff) begin
      ss_seen_ff <= 1'b1;
    end
  end

  // power ok: low before soft start ends and on undervoltage
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      power_ok_flag_o <= 1'b0;
    end else begin
      power_ok_flag_o <= ss_seen_ff && !uv_ff && run;
    end
  end

  // overvoltage latch; only enable low releases it
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ov_latch_ff <= 1'b0;
    end else if (ov_ff) begin
      ov_latch_ff <= 1'b1;
    end else if (!en_ff) begin
      ov_latch_ff <= 1'b0;
    end
  end

  // crowbar drive follows the latch
  assign overvoltage_crowbar_out_o = ov_latch_ff;
endmodule

// File: verif/mpps_seq_chk.sv
// assertion checker bound to the phase sequencer top
`timescale 1ns/1ps
module mpps_seq_chk import mpps_pkg::*; (
  input wire logic          core_clk_i,
  input wire logic          reset_n_i,
  input wire logic          logic_enable_in_i,
  input wire logic [15:0]   freq_set_input_i,
  input wire mpps_mon_type  mon_i,
  input wire logic          phase_out_a_o,
  input wire logic          phase_out_c_o,
  input wire logic          phase_out_d_o,
  input wire logic          phase_oe_o,
  input wire logic [3:0]    sense_active_o,
  input wire logic          cycle_start_o,
  input wire mpps_chan_type chan_mode_o,
  input wire logic          power_ok_flag_o,
  input wire logic          overvoltage_crowbar_out_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [15:0] eff_ff;     // clamped period, taken only while stopped
  logic [15:0] pcnt_ff;    // cycles since the last period start
  logic [15:0] lowcnt_ff;  // cycles phase a has been low
  logic        seen_ff;    // a start was seen in this run
  // the pin may move a few cycles before the stop is seen, so take it only while stopped
  // period and low-time counters; seen drops while stopped so a restart is not judged
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      eff_ff    <= 16'h000C;
      pcnt_ff   <= 16'h0000;
      lowcnt_ff <= 16'h0000;
      seen_ff   <= 1'b0;
    end else begin
      if (!phase_oe_o) begin
        eff_ff <= (freq_set_input_i < 16'h000C) ? 16'h000C : freq_set_input_i;
      end
      pcnt_ff   <= cycle_start_o ? 16'h0001 : pcnt_ff + 16'h0001;
      lowcnt_ff <= phase_out_a_o ? 16'h0000 : lowcnt_ff + 16'h0001;
      seen_ff   <= phase_oe_o & (seen_ff | cycle_start_o);
    end
  end
  sequence s_en_held;
    logic_enable_in_i [*5];
  endsequence
  sequence s_ov_held;
    mon_i.overvoltage [*6];
  endsequence
  // enable low with soft start not done: the next run must start from scratch
  sequence s_rearm;
    (!logic_enable_in_i && !mon_i.soft_start_done) [*5];
  endsequence
  a_period_len: assert property (
      cycle_start_o && seen_ff |-> pcnt_ff == eff_ff)
    else $error("period length wrong");
  // a stop also drops the outputs, so only falls seen while running are judged
  a_start_fall: assert property (
      $fell(phase_out_a_o) && phase_oe_o |-> ##[0:1] cycle_start_o)
    else $error("phase a fell away from period start");
  a_off_time: assert property (
      $rose(phase_out_a_o) |-> lowcnt_ff >= eff_ff / 16'h0003)
    else $error("phase a off time too short");
  a_two_quiet: assert property (
      chan_mode_o == MPPS_CH_TWO |->
        !phase_out_c_o && !phase_out_d_o && sense_active_o[3:2] == 2'b00)
    else $error("unused phase active in two mode");
  a_three_quiet: assert property (
      chan_mode_o == MPPS_CH_THREE |-> !phase_out_d_o && !sense_active_o[3])
    else $error("unused phase active in three mode");
  a_mode_fixed: assert property (
      phase_oe_o && $past(phase_oe_o) |-> $stable(chan_mode_o))
    else $error("channel count changed while running");
  a_crowbar_hold: assert property (
      s_en_held ##0 overvoltage_crowbar_out_o |=> overvoltage_crowbar_out_o)
    else $error("crowbar dropped while enabled");
  a_crowbar_set: assert property (s_ov_held |-> overvoltage_crowbar_out_o)
    else $error("crowbar not raised");
  a_fault_clear: assert property (
      (!logic_enable_in_i && !mon_i.overvoltage) [*6] |-> !overvoltage_crowbar_out_o)
    else $error("crowbar not cleared by enable low");
  a_pok_soft: assert property (
      s_rearm ##1 !mon_i.soft_start_done [*8] |-> !power_ok_flag_o)
    else $error("power ok before soft start done");
  a_pok_uv: assert property (mon_i.undervoltage [*6] |-> !power_ok_flag_o)
    else $error("power ok during undervoltage");
endmodule
bind mpps_seq mpps_seq_chk u_chk (.core_clk_i, .reset_n_i, .logic_enable_in_i,
  .freq_set_input_i, .mon_i, .phase_out_a_o, .phase_out_c_o, .phase_out_d_o, .phase_oe_o,
  .sense_active_o, .cycle_start_o, .chan_mode_o, .power_ok_flag_o, .overvoltage_crowbar_out_o);

// File: verif/mpps_drv_model.sv
// driver stage model: break-before-make gate control for each phase
`timescale 1ns/1ps
module mpps_drv_model (
  input  wire logic       core_clk_i,
  input  wire logic [3:0] pwm_i,
  output logic      [3:0] hi_gate_o,
  output logic      [3:0] lo_gate_o
);
  // a gate turns on only once the other has been seen off, trading a cycle for no overlap
  always_ff @(posedge core_clk_i) begin
    hi_gate_o <= pwm_i & ~lo_gate_o;
    lo_gate_o <= ~pwm_i & ~hi_gate_o;
  end
endmodule

// File: verif/testbench.sv
// self-checking bench for the phase sequencer top
`timescale 1ns/1ps
module testbench;
  import mpps_pkg::*;
  logic              core_clk_i, reset_n_i, en, tie_c, tie_d, cyc_st, oe, pok, overvoltage_crowbar_out;
  logic [15:0]       freq;
  mpps_phase_in_type pin;
  mpps_mon_type      mon;
  wire  [3:0]        pw;
  logic [3:0]        pw_q, sact, hi_g, lo_g;
  mpps_chan_type     mode;
  int                mismatches, n_tests, cyc, prev_a, hi_n;
  int                fall_cyc[4];
  // strap pins read the pull level only while the sequencer does not drive them
  mpps_seq DUT (.core_clk_i, .reset_n_i, .logic_enable_in_i(en), .freq_set_input_i(freq),
    .phase_in_i(pin), .mon_i(mon), .strap_c_i(oe ? pw[2] : tie_c),
    .strap_d_i(oe ? pw[3] : tie_d), .phase_out_a_o(pw[0]), .phase_out_b_o(pw[1]),
    .phase_out_c_o(pw[2]), .phase_out_d_o(pw[3]), .phase_oe_o(oe), .sense_active_o(sact),
    .cycle_start_o(cyc_st), .chan_mode_o(mode), .power_ok_flag_o(pok),
    .overvoltage_crowbar_out_o(overvoltage_crowbar_out));
  mpps_drv_model u_drv (.core_clk_i, .pwm_i(pw), .hi_gate_o(hi_g), .lo_gate_o(lo_g));
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // fall log per phase, sampled at the quiet edge
  always @(negedge core_clk_i) begin
    cyc <= cyc + 1;
    pw_q <= pw;
    for (int g = 0; g < 4; g++) if (pw_q[g] && !pw[g]) fall_cyc[g] <= cyc;
    if (pw_q[0] && !pw[0]) prev_a <= fall_cyc[0];
    if (|(hi_g & lo_g)) begin
      mismatches++;
      $display("BAD gate_overlap expected 0 seen %0h", hi_g & lo_g);
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // stop, strap, restart, then judge one period of falls against the spacing
  task automatic run_mode(input logic sc, sd, input logic [15:0] f, input int n,
                          input mpps_chan_type m);
    int p, k;
    p = (f < 16'h000C) ? 12 : f;
    en = 1'b0;
    tie_c = sc;
    tie_d = sd;
    freq = f;
    tick(8);
    chk("oe_stopped", 1'b0, oe);
    en = 1'b1;
    tick(4 * p + 10);
    k = 0;
    while (cyc_st !== 1'b1 && k < 100) begin
      tick(1);
      k++;
    end
    tick(1);
    chk("mode", m, mode);
    chk("period", p, fall_cyc[0] - prev_a);
    for (int g = 1; g < n; g++)
      chk("gap", p - g * (p / n), fall_cyc[0] - fall_cyc[g]);
    for (int g = n; g < 4; g++) chk("idle_out", 2'b00, {pw[g], sact[g]});
    tick(p / 3 - 2);
    chk("a_off", 1'b0, pw[0]);
    chk("a_sense_on", 1'b1, sact[0]);
    tick(5);
    chk("a_rise", 1'b1, pw[0]);
    chk("a_sense_off", 1'b0, sact[0]);
  endtask
  initial begin
    {en, tie_c, tie_d, reset_n_i, cyc, prev_a, mismatches, n_tests} = '0;
    freq = 16'h0018;
    pin = '{ramp_cross: 4'hF, sense_valid: 4'hF};
    mon = '{soft_start_done: 1'b1, undervoltage: 1'b0, overvoltage: 1'b0};
    tick(16);
    chk("rst_mode", MPPS_CH_FOUR, mode);
    chk("rst_out", 3'b000, {pw[0], pok, overvoltage_crowbar_out});
    reset_n_i = 1'b1;
    run_mode(1'b1, 1'b0, 16'h0018, 2, MPPS_CH_TWO);
    run_mode(1'b0, 1'b1, 16'h0018, 3, MPPS_CH_THREE);
    run_mode(1'b1, 1'b1, 16'h0018, 2, MPPS_CH_TWO);
    run_mode(1'b0, 1'b0, 16'h0008, 4, MPPS_CH_FOUR);
    run_mode(1'b0, 1'b0, 16'h0018, 4, MPPS_CH_FOUR);
    pin.ramp_cross = 4'hD;
    // a pulse already high runs on to its own termination, so let a period pass first
    tick(26);
    hi_n = 0;
    repeat (48) begin
      tick(1);
      hi_n += pw[1];
    end
    chk("b_no_cross", 0, hi_n);
    pin.ramp_cross = 4'hF;
    tick(8);
    chk("pok_run", 1'b1, pok);
    // soft start counts as done once per enable, so rearm it through enable low
    mon.soft_start_done = 1'b0;
    en = 1'b0;
    tick(8);
    en = 1'b1;
    tick(12);
    chk("pok_soft", 1'b0, pok);
    chk("oe_rerun", 1'b1, oe);
    mon.soft_start_done = 1'b1;
    tick(8);
    chk("pok_ss_done", 1'b1, pok);
    mon.undervoltage = 1'b1;
    tick(8);
    chk("pok_uv", 1'b0, pok);
    mon.undervoltage = 1'b0;
    mon.overvoltage = 1'b1;
    tick(8);
    chk("ovp_set", 1'b1, overvoltage_crowbar_out);
    mon.overvoltage = 1'b0;
    tick(8);
    chk("ovp_held", 1'b1, overvoltage_crowbar_out);
    en = 1'b0;
    tick(8);
    chk("ovp_clr", 1'b0, overvoltage_crowbar_out);
    test_done();
  end
  initial begin
    #400000;
    mismatches++;
    $display("BAD watchdog expected done seen hang");
    test_done();
  end
endmodule
